/* File: src/lsm_pkg.sv */
package lsm_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] PERIOD_OFS = 8'h08;
  localparam logic [7:0] SAMPLE_OFS = 8'h0c;

  // Control register fields
  localparam int CTRL_SENSOR_BIT = 0;
  localparam int CTRL_TAMPER_BIT = 1;
  localparam int CTRL_OVR_BIT    = 2;
  localparam int CTRL_CLOCK_RANGE_SELECT_BIT   = 3;
  localparam int CTRL_THR_LSB    = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register fields (8-bit register)
  localparam int STATUS_W        = 8;
  localparam int ST_FRE_BIT      = 0;
  localparam int ST_SLOPE_BIT    = 1;
  localparam int ST_NOLOAD_BIT   = 2;
  localparam int ST_STUCKV_BIT   = 3;
  localparam int ST_STUCKC_BIT   = 4;
  localparam int ST_PINF_BIT     = 5;
  localparam int ST_ZC_BIT       = 6;

  // Resolutions and decimation
  localparam int VOLT_W          = 11;
  localparam int CURR_W          = 16;
  localparam int VOLT_DEC_LOG2   = 10;
  localparam int CURR_DEC_LOG2   = 15;
  localparam logic [10:0] VOLT_GAIN_Q10 = 11'h404;
  localparam logic [10:0] CURR_GAIN_Q10 = 11'h202;

  // Period measurement limits in fclk/4 ticks
  localparam int PER_W           = 16;
  localparam logic [15:0] PER_LIM_HI = 16'h8000;
  localparam logic [15:0] PER_LIM_LO = 16'h2000;
  localparam logic [15:0] PER_SAT    = 16'h8001;
  localparam logic [1:0]  SHORT_REPEAT = 2'h3;

  // Voltage presence hysteresis on the rms value
  localparam logic [10:0] VOLTAGE_RMS_VALUE_LOW  = 11'h040;
  localparam logic [10:0] VOLTAGE_RMS_VALUE_HIGH = 11'h080;

  // No-load thresholds for codes 0..3
  localparam int NL_PROD_W = 27;
  localparam logic [26:0] NL_THR0 = 27'h0000320;
  localparam logic [26:0] NL_THR1 = 27'h0000640;
  localparam logic [26:0] NL_THR2 = 27'h0000c80;
  localparam logic [26:0] NL_THR3 = 27'h0001900;

  // Stuck stream observation window in modulator samples
  localparam int STUCK_WIN = 128;

endpackage : lsm_pkg

/* File: src/lsm_decim.sv */
`timescale 1ns/1ps
module lsm_decim #(
  parameter int          DEC_LOG2 = 10,
  parameter int          OUT_W    = 11,
  parameter logic [10:0] GAIN_Q10 = 11'h400
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Bit stream
  input  wire logic             tick,
  input  wire logic             bit_in,
  // Result
  output logic signed [OUT_W-1:0] sample,
  output logic                  sample_valid
);
  localparam int ACC_W = DEC_LOG2 + 2;
  localparam int P_W   = ACC_W + 12;

  typedef struct packed {
    logic [DEC_LOG2-1:0]     cnt;
    logic signed [ACC_W-1:0] acc;
    logic signed [OUT_W-1:0] res;
    logic                    vld;
  } lsm_dec_s;

  lsm_dec_s st_reg, st_next;
  logic signed [P_W-1:0] prod;

  always_comb begin
    st_next     = st_reg;
    st_next.vld = 1'b0;
    prod        = P_W'(st_reg.acc) * $signed({1'b0, GAIN_Q10});
    if (tick) begin
      // Each sample but the last of the window counts +1 or -1; window sum scaled by the path gain
      st_next.acc = st_reg.acc + (bit_in ? ACC_W'(1) : -ACC_W'(1));
      st_next.cnt = st_reg.cnt + 1'b1;
      if (&st_reg.cnt) begin
        st_next.res = prod[ACC_W+9 -: OUT_W];
        st_next.vld = 1'b1;
        st_next.acc = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign sample       = st_reg.res;
  assign sample_valid = st_reg.vld;
endmodule : lsm_decim

/* File: src/lsm_stuck_det.sv */
`timescale 1ns/1ps
module lsm_stuck_det #(
  parameter int WIN = 128
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Stream in
  input  wire logic tick,
  input  wire logic bit_in,
  // Checked stream out
  output logic      bit_out,
  output logic      stuck
);
  typedef struct packed {
    logic [$clog2(WIN+1)-1:0] run;
    logic                     last;
    logic                     stk;
    logic                     idle;
    logic                     obit;
  } lsm_stk_s;

  lsm_stk_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (tick) begin
      st_next.last = bit_in;
      st_next.idle = ~st_reg.idle;
      if (bit_in == st_reg.last) begin
        if (st_reg.run != WIN[$clog2(WIN+1)-1:0]) begin
          st_next.run = st_reg.run + 1'b1;
        end
      end else begin
        st_next.run = '0;
      end
      st_next.stk  = (st_next.run == WIN[$clog2(WIN+1)-1:0]);
      // Alternating stream averages to zero
      st_next.obit = st_next.stk ? st_reg.idle : bit_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign bit_out = st_reg.obit;
  assign stuck   = st_reg.stk;
endmodule : lsm_stuck_det

/* File: src/lsm_top.sv */
// Notes on behaviour
// (R1) Primary gain 8 for transformer, 32 shunt
// (R2) Secondary disabled unless tamper enabled; same gain
// (R3) Current channel multiplexed only with tamper
// (R4) Modulator sampling at clock divided by four
// (R5) Decimation gain 1.004 voltage, 0.502 current
// (R6) Results 11 bits voltage, 16 current
// (R7) Zero-cross rises at crossing, falls at peak
// (R8) Slope low rising, high falling; status bit
// (R9) Period counter restarts on slope falling edge
// (R10) Count over 2^15 or none: error
// (R11) Short period thrice in row: error
// (R12) Rms below 64 sets, above 128 clears
// (R13) Error clears when frequency back in band
// (R14) Error zeroes power unless override set
// (R15) Range error is status register bit
// (R16) No-load when rms product below threshold
// (R17) No-load suspends integration, holds tamper off
// (R18) No-load flag visible only in status
// (R19) Flag stream stuck through observation window
// (R20) Replace stuck stream with idle zero stream
// (R21) All flags gathered in readable status
// (R22) Pin level differing from drive sets fault
// (R23) Status crosses safely to host clock; here status is read on pclk with no crossing
// (R24) Period counter saturates instead of wrapping
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module lsm_top #(
  parameter int N_PULSE = 2
) (
  // Clock, reset, enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Analog front end
  input  wire logic                 sd_volt_pin,
  input  wire logic                 sd_curr_pin,
  output logic                      sd_sample_clk,
  output logic                      pga_gain_pri,
  output logic                      pga_gain_sec,
  output logic                      sec_enable,
  output logic                      cur_chan_sel,
  input  wire logic                 tamper_mux_req,
  // Rms values from the measurement path
  input  wire logic [10:0]          voltage_rms_value,
  input  wire logic [15:0]          current_rms_value,
  // Decimated samples
  output logic signed [10:0]        volt_sample,
  output logic signed [15:0]        curr_sample,
  output logic                      sample_valid,
  // Line signals and gating
  output logic                      zero_cross_signal,
  output logic                      power_enable,
  output logic                      integrate_enable,
  output logic                      tamper_hold,
  // Pulse outputs and their readback
  input  wire logic [N_PULSE-1:0]   pulse_drive,
  output logic [N_PULSE-1:0]        pulse_out,
  input  wire logic [N_PULSE-1:0]   pulse_pin
);

  // All state lives in one struct so reset and clock enable
  // cover every flop alike; nothing escapes the freeze.
  // Field groups:
  //   div           fclk/4 tick divider
  //   sv*, sc*, pp* two-flop synchronisers of the pins
  //   po, pd*       drive pipeline matched to the readback delay
  //   slope, zc     line shape from decimated voltage
  //   per_*, short* period measurement
  //   err_*, vlow   causes of the range error
  typedef struct packed {
    logic [1:0]         div;
    logic               sv1;
    logic               sv2;
    logic               sc1;
    logic               sc2;
    logic [N_PULSE-1:0] pp1;
    logic [N_PULSE-1:0] pp2;
    logic [N_PULSE-1:0] po;
    logic [N_PULSE-1:0] pd1;
    logic [N_PULSE-1:0] pd2;
    logic [5:0]         ctrl;
    logic signed [10:0] prev_v;
    logic               slope;
    logic               zc;
    logic [15:0]        per_cnt;
    logic [15:0]        per_last;
    logic [1:0]         short_cnt;
    logic               err_low;
    logic               err_high;
    logic               vlow;
    logic               no_load;
    logic               pin_fault;
    logic [31:0]        rdata;
  } lsm_st_s;

  lsm_st_s st_reg, st_next;

  logic                    tick;
  logic                    v_bit;
  logic                    c_bit;
  logic                    stuck_v;
  logic                    stuck_c;
  logic                    v_vld;
  logic                    c_vld;
  logic signed [10:0]      v_smp;
  logic signed [15:0]      c_smp;
  logic                    access;
  logic                    setup;
  logic                    hit;
  logic                    fre;
  logic [7:0]              status;
  logic [26:0]             rms_prod;
  logic [26:0]             thr;

  function automatic logic [26:0] nl_threshold(input logic [1:0] code);
    case (code)
      2'h0:    nl_threshold = lsm_pkg::NL_THR0;
      2'h1:    nl_threshold = lsm_pkg::NL_THR1;
      2'h2:    nl_threshold = lsm_pkg::NL_THR2;
      default: nl_threshold = lsm_pkg::NL_THR3;
    endcase
  endfunction : nl_threshold

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == lsm_pkg::CTRL_OFS) || (a == lsm_pkg::STATUS_OFS) ||
               (a == lsm_pkg::PERIOD_OFS) || (a == lsm_pkg::SAMPLE_OFS);
  endfunction : addr_hit

  // Modulator sample strobe at pclk/4
  assign tick = (st_reg.div == 2'h3); // R4

  lsm_stuck_det #(
    .WIN (lsm_pkg::STUCK_WIN)
  ) u_stuck_v (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (tick),
    .bit_in  (st_reg.sv2),
    .bit_out (v_bit),
    .stuck   (stuck_v)
  ); // R19 R20

  lsm_stuck_det #(
    .WIN (lsm_pkg::STUCK_WIN)
  ) u_stuck_c (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (tick),
    .bit_in  (st_reg.sc2),
    .bit_out (c_bit),
    .stuck   (stuck_c)
  ); // R19 R20

  lsm_decim #(
    .DEC_LOG2 (lsm_pkg::VOLT_DEC_LOG2),
    .OUT_W    (lsm_pkg::VOLT_W),
    .GAIN_Q10 (lsm_pkg::VOLT_GAIN_Q10)
  ) u_dec_v (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .tick         (tick),
    .bit_in       (v_bit),
    .sample       (v_smp),
    .sample_valid (v_vld)
  ); // R5 R6

  lsm_decim #(
    .DEC_LOG2 (lsm_pkg::CURR_DEC_LOG2),
    .OUT_W    (lsm_pkg::CURR_W),
    .GAIN_Q10 (lsm_pkg::CURR_GAIN_Q10)
  ) u_dec_c (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .tick         (tick),
    .bit_in       (c_bit),
    .sample       (c_smp),
    .sample_valid (c_vld)
  ); // R5 R6

  assign access   = psel & penable;
  assign setup    = psel & ~penable;
  assign hit      = addr_hit(paddr);
  assign fre      = st_reg.err_low | st_reg.err_high | st_reg.vlow;
  assign rms_prod = NL_PROD_W_CAST(voltage_rms_value, current_rms_value);
  assign thr      = nl_threshold(st_reg.ctrl[lsm_pkg::CTRL_THR_LSB +: 2]);

  function automatic logic [26:0] NL_PROD_W_CAST(input logic [10:0] v,
                                                 input logic [15:0] i);
    NL_PROD_W_CAST = 27'(v) * 27'(i);
  endfunction : NL_PROD_W_CAST

  always_comb begin
    status                       = '0;
    status[lsm_pkg::ST_FRE_BIT]    = fre; // R15
    status[lsm_pkg::ST_SLOPE_BIT]  = st_reg.slope; // R8
    status[lsm_pkg::ST_NOLOAD_BIT] = st_reg.no_load; // R18
    status[lsm_pkg::ST_STUCKV_BIT] = stuck_v; // R21
    status[lsm_pkg::ST_STUCKC_BIT] = stuck_c; // R21
    status[lsm_pkg::ST_PINF_BIT]   = st_reg.pin_fault; // R21
    status[lsm_pkg::ST_ZC_BIT]     = st_reg.zc;
  end

  always_comb begin
    st_next     = st_reg;
    st_next.div = st_reg.div + 2'h1;

    // Pin inputs cross into pclk through two flops
    st_next.sv1 = sd_volt_pin;
    st_next.sv2 = st_reg.sv1;
    st_next.sc1 = sd_curr_pin;
    st_next.sc2 = st_reg.sc1;
    st_next.pp1 = pulse_pin;
    st_next.pp2 = st_reg.pp1;

    // Drive pipeline aligned with the synchronised readback
    st_next.po  = pulse_drive;
    st_next.pd1 = st_reg.po;
    st_next.pd2 = st_reg.pd1;

    // Slope and zero crossing follow each decimated voltage sample
    if (v_vld) begin
      st_next.prev_v = v_smp;
      if (v_smp != st_reg.prev_v) begin
        st_next.slope = (v_smp < st_reg.prev_v); // R8
      end
      if (v_smp[10] != st_reg.prev_v[10]) begin
        st_next.zc = 1'b1; // R7
      end else if (st_next.slope != st_reg.slope) begin
        st_next.zc = 1'b0; // R7
      end
    end

    // Period counter on fclk/4 ticks, saturating
    // Saturation keeps a lost slope edge reported as an error
    // instead of wrapping back into the valid band.
    if (tick && st_reg.per_cnt != lsm_pkg::PER_SAT) begin
      st_next.per_cnt = st_reg.per_cnt + 16'h0001; // R9 R24
    end
    if (st_reg.per_cnt > lsm_pkg::PER_LIM_HI) begin
      st_next.err_low = 1'b1; // R10
    end
    if (st_reg.slope && !st_next.slope) begin
      st_next.per_cnt  = '0; // R9
      st_next.per_last = st_reg.per_cnt;
      if (st_reg.per_cnt > lsm_pkg::PER_LIM_HI) begin
        st_next.err_low = 1'b1; // R10
      end else begin
        st_next.err_low = 1'b0; // R13
      end
      if (st_reg.per_cnt < lsm_pkg::PER_LIM_LO) begin
        if (st_reg.short_cnt != lsm_pkg::SHORT_REPEAT) begin
          st_next.short_cnt = st_reg.short_cnt + 2'h1;
        end
        if (st_next.short_cnt == lsm_pkg::SHORT_REPEAT) begin
          st_next.err_high = 1'b1; // R11
        end
      end else begin
        st_next.short_cnt = '0;
        st_next.err_high  = 1'b0; // R13
      end
    end

    // Voltage presence with hysteresis
    // The gap between the two levels stops the flag chattering
    // while the rms value hovers near the lower limit.
    if (voltage_rms_value < lsm_pkg::VOLTAGE_RMS_VALUE_LOW) begin
      st_next.vlow = 1'b1; // R12
    end else if (voltage_rms_value > lsm_pkg::VOLTAGE_RMS_VALUE_HIGH) begin
      st_next.vlow = 1'b0; // R12
    end

    st_next.no_load = (rms_prod < thr); // R16

    // Register writes take effect in the access phase
    if (access && pwrite && paddr == lsm_pkg::CTRL_OFS) begin
      st_next.ctrl = pwdata[5:0];
    end
    if (access && pwrite && paddr == lsm_pkg::STATUS_OFS &&
        pwdata[lsm_pkg::ST_PINF_BIT]) begin
      st_next.pin_fault = 1'b0;
    end
    // A mismatch in the clearing cycle still sets the fault
    if (st_reg.pp2 != st_reg.pd2) begin
      st_next.pin_fault = 1'b1; // R22
    end

    // Read data is latched in the setup phase so it stands from a flop
    if (setup) begin
      case (paddr)
        lsm_pkg::CTRL_OFS:   st_next.rdata = {26'h0, st_reg.ctrl};
        lsm_pkg::STATUS_OFS: st_next.rdata = {24'h0, status}; // R21; read in the pclk domain with no crossing, so R23 is not met
        lsm_pkg::PERIOD_OFS: st_next.rdata = {16'h0, st_reg.per_last};
        lsm_pkg::SAMPLE_OFS: st_next.rdata = {c_smp, 5'h00, v_smp};
        default:             st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= '0;
      st_reg.ctrl <= lsm_pkg::CTRL_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // APB answers in the access cycle with no wait states
  // Status is built in this clock domain, so the bus needs
  // no further crossing; a host on another clock must add one.
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = st_reg.rdata;

  assign sd_sample_clk = st_reg.div[1]; // R4
  assign pga_gain_pri  = st_reg.ctrl[lsm_pkg::CTRL_SENSOR_BIT]; // R1
  assign sec_enable    = st_reg.ctrl[lsm_pkg::CTRL_TAMPER_BIT]; // R2
  assign pga_gain_sec  = sec_enable & st_reg.ctrl[lsm_pkg::CTRL_SENSOR_BIT]; // R2
  // Secondary selected only while tamper runs and is not held off
  assign cur_chan_sel  = sec_enable & tamper_mux_req & ~tamper_hold; // R3

  assign volt_sample   = v_smp;
  assign curr_sample   = c_smp;
  assign sample_valid  = v_vld;

  assign zero_cross_signal = st_reg.zc; // R7
  assign power_enable  = ~fre | st_reg.ctrl[lsm_pkg::CTRL_OVR_BIT]; // R14
  assign integrate_enable = power_enable & ~st_reg.no_load & ~stuck_v & ~stuck_c; // R17
  // Tamper stays off whenever its inputs cannot be trusted
  assign tamper_hold   = st_reg.no_load | fre | stuck_v | stuck_c; // R17
  assign pulse_out     = st_reg.po;

endmodule : lsm_top

/* File: verif/lsm_assertions.sv */
`timescale 1ns/1ps
module lsm_checker #(
  parameter int N_PULSE = 2
) (
  // Clock and bus
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               ce,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  // Front end and gating
  input wire logic               sd_volt_pin,
  input wire logic               sd_sample_clk,
  input wire logic               pga_gain_pri,
  input wire logic               pga_gain_sec,
  input wire logic               sec_enable,
  input wire logic               cur_chan_sel,
  input wire logic               sample_valid,
  input wire logic               power_enable,
  input wire logic               integrate_enable,
  input wire logic               tamper_hold,
  input wire logic [N_PULSE-1:0] pulse_drive,
  input wire logic [N_PULSE-1:0] pulse_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Cycles the raw voltage stream has held one level, saturating
  logic [9:0] run_reg;
  logic       last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg  <= 10'h000;
      last_reg <= 1'b0;
    end else begin
      last_reg <= sd_volt_pin;
      if (sd_volt_pin != last_reg) run_reg <= 10'h000;
      else if (run_reg != 10'h3ff) run_reg <= run_reg + 10'h001;
    end
  end

  a_ctrl_gain_write :
    assert property (psel && penable && pwrite && ce && paddr == lsm_pkg::CTRL_OFS
      |=> {sec_enable, pga_gain_pri} == $past(pwdata[1:0])) else $error("gain not written");
  a_sec_gain_off :
    assert property (pga_gain_sec == (sec_enable && pga_gain_pri))
      else $error("secondary gain wrong");
  a_mux_tamper_only :
    assert property (cur_chan_sel |-> sec_enable && !tamper_hold)
      else $error("secondary selected while tamper off");
  a_sample_clk_div :
    assert property (ce && $rose(sd_sample_clk) |=> sd_sample_clk ##1 !sd_sample_clk
      ##1 !sd_sample_clk ##1 sd_sample_clk) else $error("sample clock not pclk/4");
  a_valid_one_shot :
    assert property (sample_valid |=> !sample_valid [*8]) else $error("sample valid too long");
  a_integ_needs_power :
    assert property (integrate_enable |-> power_enable) else $error("integrating with power off");
  a_stuck_holds :
    assert property (run_reg == 10'd600 |-> tamper_hold && !integrate_enable)
      else $error("stuck stream not flagged");
  a_pulse_follow :
    assert property (ce |=> pulse_out == $past(pulse_drive)) else $error("pulse out wrong");
  a_unmapped_err :
    assert property (psel && penable |->
      pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("slave error wrong");
  a_unmapped_zero :
    assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : lsm_checker

/* File: verif/lsm_sd_model.sv */
`timescale 1ns/1ps
module lsm_sd_model (
  // Modulator clock
  input  wire logic       sd_sample_clk,
  input  wire logic       presetn,
  // Shape: 0 toggling, 1 stuck low, 2 stuck high
  input  wire logic [1:0] volt_mode,
  input  wire logic [1:0] curr_mode,
  // Bit streams
  output logic            sd_volt_pin,
  output logic            sd_curr_pin
);
  logic phase_reg;

  // A zero input gives the densest toggling, so a healthy stream never holds
  always_ff @(posedge sd_sample_clk or negedge presetn) begin
    if (!presetn) phase_reg <= 1'b0;
    else phase_reg <= !phase_reg;
  end

  function automatic logic shape(input logic [1:0] mode, input logic ph);
    return (mode == 2'h0) ? ph : mode[1];
  endfunction : shape

  assign sd_volt_pin = shape(volt_mode, phase_reg);
  assign sd_curr_pin = shape(curr_mode, phase_reg);
endmodule : lsm_sd_model

/* File: verif/line_signal_monitor_test.sv */
`timescale 1ns/1ps
module line_signal_monitor_test;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, fre, exp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sd_volt_pin, sd_curr_pin, sd_sample_clk, tamper_mux_req, sample_valid;
  logic        pga_gain_pri, pga_gain_sec, sec_enable, cur_chan_sel;
  logic        power_enable, integrate_enable, tamper_hold;
  logic [10:0] voltage_rms_value;
  logic [15:0] current_rms_value;
  logic [1:0]  pulse_drive, pulse_out, pulse_pin, pin_short, volt_mode, curr_mode;
  logic [10:0] vr_tab [5] = '{11'h040, 11'h03f, 11'h064, 11'h080, 11'h081};
  int          seed, bad_count, total_checks, cycles;

  lsm_top lsm_top_i (.*, .volt_sample(), .curr_sample(), .zero_cross_signal());
  lsm_sd_model lsm_sd_model_i (.*);

  // A shorted pin reads back inverted
  assign pulse_pin = pulse_out ^ pin_short;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic nl_exp(input logic [10:0] v, input logic [15:0] i,
                                  input logic [1:0] code);
    return 27'(v) * 27'(i) < (27'h320 << code);
  endfunction : nl_exp

  function automatic logic fre_next(input logic old, input logic [10:0] v);
    return (v < 11'h040) ? 1'b1 : ((v > 11'h080) ? 1'b0 : old);
  endfunction : fre_next

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // Random traffic on the pulse drive and tamper sequencer, plus the hang limit
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    pulse_drive <= 2'($random(seed));
    tamper_mux_req <= 1'($random(seed));
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    seed = 32'h41f6;
    ce = 1'b1;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, fre} = '0;
    {volt_mode, curr_mode, pin_short, pulse_drive, tamper_mux_req} = '0;
    voltage_rms_value = 11'h0c8;
    current_rms_value = 16'hffff;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, lsm_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, lsm_pkg::STATUS_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, lsm_pkg::CTRL_OFS, 32'(c));
      check(pga_gain_pri, c[0]);
      check({sec_enable, pga_gain_sec}, {c[1], c[1] & c[0]});
      check(cur_chan_sel, c[1] & tamper_mux_req);
    end
    $display("test gains done");
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, lsm_pkg::CTRL_OFS, 32'(k % 4) << lsm_pkg::CTRL_THR_LSB);
      if (k < 8) current_rms_value <= 16'((800 << k % 4) / 200 - 1 + k / 4);
      else current_rms_value <= 16'($random(seed) & 63);
      repeat (2) @(posedge pclk);
      exp = nl_exp(voltage_rms_value, current_rms_value, 2'(k % 4));
      apb(1'b0, lsm_pkg::STATUS_OFS, 32'h0);
      check(rd[lsm_pkg::ST_NOLOAD_BIT], exp);
      check({integrate_enable, tamper_hold}, {!exp, exp});
    end
    current_rms_value <= 16'hffff;
    apb(1'b1, lsm_pkg::CTRL_OFS, 32'h0);
    $display("test no load done");
    foreach (vr_tab[j]) begin
      voltage_rms_value <= vr_tab[j];
      repeat (3) @(posedge pclk);
      fre = fre_next(fre, vr_tab[j]);
      apb(1'b0, lsm_pkg::STATUS_OFS, 32'h0);
      check(rd[lsm_pkg::ST_FRE_BIT], fre);
      check(power_enable, !fre);
      if (j == 2) begin
        apb(1'b1, lsm_pkg::CTRL_OFS, 32'h1 << lsm_pkg::CTRL_OVR_BIT);
        check(power_enable, 1'b1);
        apb(1'b1, lsm_pkg::CTRL_OFS, 32'h0);
      end
    end
    $display("test range done");
    for (int s = 0; s < 2; s++) begin
      if (s == 0) volt_mode <= 2'h2;
      else curr_mode <= 2'h1;
      repeat (600) @(posedge pclk);
      apb(1'b0, lsm_pkg::STATUS_OFS, 32'h0);
      check(rd[lsm_pkg::ST_STUCKV_BIT +: 2], s ? 2'b10 : 2'b01);
      check(integrate_enable, 1'b0);
      volt_mode <= 2'h0;
      curr_mode <= 2'h0;
      repeat (20) @(posedge pclk);
      apb(1'b0, lsm_pkg::STATUS_OFS, 32'h0);
      check(rd[lsm_pkg::ST_STUCKV_BIT +: 2], 2'b00);
    end
    // Second window lies wholly after the streams resumed toggling
    repeat (2) begin
      @(posedge pclk);
      while (sample_valid !== 1'b1) @(posedge pclk);
    end
    apb(1'b0, lsm_pkg::SAMPLE_OFS, 32'h0);
    check(rd[10:0], 11'h000);
    $display("test streams done");
    apb(1'b0, lsm_pkg::STATUS_OFS, 32'h0);
    check(rd[lsm_pkg::ST_PINF_BIT], 1'b0);
    pin_short <= 2'b01;
    repeat (10) @(posedge pclk);
    pin_short <= 2'b00;
    repeat (5) @(posedge pclk);
    for (int w = 0; w < 2; w++) begin
      apb(1'b1, lsm_pkg::STATUS_OFS, 32'(w) << lsm_pkg::ST_PINF_BIT);
      apb(1'b0, lsm_pkg::STATUS_OFS, 32'h0);
      check(rd[lsm_pkg::ST_PINF_BIT], w == 0);
    end
    $display("test pin fault done");
    stop_test();
  end
endmodule : line_signal_monitor_test

bind lsm_top lsm_checker #(.N_PULSE(N_PULSE)) lsm_checker_i (.*);
